// ---- verilog/cta_pkg.sv ----
// Register indices, field layouts and types for the cache and TLB test block.
package cta_pkg;
  // Test register indices on the model-specific register port.
  localparam logic [7:0] IDX_END  = 8'h04;
  localparam logic [7:0] IDX_DATA = 8'h05;
  localparam logic [7:0] IDX_STAT = 8'h06;
  localparam logic [7:0] IDX_CTRL = 8'h07;
  localparam logic [7:0] IDX_TLBC = 8'h08;
  localparam logic [7:0] IDX_TLBD = 8'h09;
  // Cache control test register fields.
  localparam int CMD_LSB  = 0;
  localparam int BUF_LSB  = 2;
  localparam int SET_LSB  = 5;
  localparam int WAY_LSB  = 12;
  localparam int CSEL_BIT = 14;
  localparam int WB_BIT   = 15;
  localparam logic [1:0] CMD_NORMAL = 2'h0;
  localparam logic [1:0] CMD_WRITE  = 2'h1;
  localparam logic [1:0] CMD_READ   = 2'h2;
  localparam logic [1:0] CMD_FLUSH  = 2'h3;
  // Cache status test register fields; bits above STAT_W read as zero after a test read.
  localparam int VAL_LSB = 0;
  localparam int TAG_LSB = 8;
  localparam int TAG_W   = 20;
  localparam int STAT_W  = 28;
  localparam logic [1:0] VAL_MOD = 2'h3;
  localparam logic [1:0] VAL_INV = 2'h0;
  // Memory address split.
  localparam int LINE_LSB = 5;
  localparam int ATAG_LSB = 12;
  // TLB command test register fields.
  localparam int OP_BIT   = 0;
  localparam int TSEL_BIT = 1;
  localparam int PS_BIT   = 7;
  localparam int W_BIT    = 8;
  localparam int U_BIT    = 9;
  localparam int D_BIT    = 10;
  localparam int V_BIT    = 11;
  localparam int LIN_LSB  = 12;
  // TLB data test register fields.
  localparam int ATTR_LSB = 2;
  localparam int HIT_BIT  = 4;
  localparam int ENT_LSB  = 5;
  localparam int ENT_W    = 6;
  localparam int PA_LSB   = 12;
  // A 4-Mbyte page compares only the upper bits of the page tag.
  localparam int PG4M_LSB = 10;

  typedef enum logic [0:0] {ST_IDLE, ST_WALK} cta_state_type;

  typedef struct packed {
    logic [19:0] tag;
    logic [19:0] pa;
    logic        v;
    logic        d;
    logic        u;
    logic        w;
    logic [1:0]  attr;
  } cta_tlb_type;
endpackage

// ---- verilog/cta_test_access.sv ----
// Test-register access to the code and data caches and the TLBs.
// Summary of operation
// - Way field picks way 0 to 3 directly; upper bit only on four ways.
// - Command field: 00 normal, 01 test write, 10 test read, 11 flush.
// - Test accesses address set and way directly, with no tag compare.
// - Test write replaces tag, LRU and valid bits with the status reg.
// - Control write with command 01 writes the staged line into the entry.
// - Command 10 copies data portion, end bits (code cache only, data reads 0) and status to test regs.
// - Flush of the code cache invalidates all of it, any writeback bit.
// - Data flush: whole cache with no writeback, or one line written back.
// - End, data and status regs are read/write; control is write-only.
// - Data access in code test: data lookup, miss kills matching code line.
// - Code miss in data test kills matching data line, modified first saved.
// - Flush pin served at instruction boundary: write back, then invalidate.
// - Data TLBs of 64 and 8 entries; one 32-entry code TLB.
// - Code TLB ignores page size and holds pages as 4-Kbyte units.
// - TLB status bits go into the entry on write, back out on read.
// - Valid, dirty, writeable and user bits keep their documented meaning.
// - Page size 0 is 4 KByte, 1 is 4 MByte; W, D, PS data TLB only.
// - A hit in both data TLBs reports the 4-Mbyte page size.
// - Operation bit 0 writes, 1 reads; TLB select 0 picks code TLB.
// - Buffer field picks one of eight portions; set picks one of 128.
// - Status register bits 31 to 28 read zero after a test read.
// - A TLB test read sets the hit bit on a valid matching entry.
`timescale 1ns/1ps
module cta_test_access #(
  parameter int SETS   = 128,
  parameter int WAYS   = 4,
  parameter int WORDS  = 8,
  parameter int CTLB   = 32,
  parameter int DTLB4K = 64,
  parameter int DTLB4M = 8
) (
  input  wire logic                  ref_clk,            // Core clock.
  input  wire logic                  rst,                // Sync reset, high.
  input  wire logic                  msr_wr,             // Register write.
  input  wire logic                  msr_rd,             // Register read.
  input  wire logic [7:0]            msr_index,          // Register index.
  input  wire logic [31:0]           msr_wdata,          // Write data.
  output logic      [31:0]           msr_rdata,          // Read data.
  output logic                       msr_rvalid,         // Read data valid.
  input  wire logic                  cache_disable_ctrl, // Test mode active.
  input  wire logic                  data_req,           // Memory data access.
  input  wire logic                  code_req,           // Code fetch access.
  input  wire logic [31:0]           snoop_addr,         // Access address.
  output logic                       ext_cycle_go,       // External cycle ok.
  input  wire logic                  flush_pin_n,        // Flush pin, low.
  input  wire logic                  instr_boundary,     // Instruction edge.
  output logic                       flush_busy,         // Flush in progress.
  output logic                       wb_req,             // Line write-back.
  output logic      [31:0]           wb_addr,            // Write-back address.
  output logic      [WORDS*32-1:0]   wb_line             // Write-back data.
);
  localparam int SW = $clog2(SETS);
  localparam int WW = 2;
  localparam int BW = $clog2(WORDS);
  localparam int LW = WORDS * 32;

  typedef struct packed {
    logic [3:0]               tr2;
    logic [31:0]              tr3;
    logic [31:0]              tr4;
    logic                     csel;
    logic                     wb;
    logic [WW-1:0]            way;
    logic [SW-1:0]            set;
    logic [BW-1:0]            bsel;
    logic [31:0]              tr6;
    logic [31:0]              tr7;
    logic [WORDS-1:0][31:0]   fill;
    logic [WORDS-1:0][3:0]    fend;
    cta_pkg::cta_state_type   st;
    logic [SW+WW-1:0]         walk;
    logic                     fpend;
    logic                     fs1;
    logic                     fs2;
    logic [31:0]              rdata;
    logic                     rvalid;
    logic                     go;
    logic                     busy;
    logic                     wbreq;
    logic [31:0]              wbaddr;
    logic [LW-1:0]            wbline;
  } cta_regs_type;

  cta_regs_type r;
  cta_regs_type n;

  logic [cta_pkg::STAT_W-1:0] cstat [2][SETS][WAYS];
  logic [31:0]                cdata [2][SETS][WAYS][WORDS];
  logic [3:0]                 cend  [SETS][WAYS][WORDS];
  cta_pkg::cta_tlb_type       ctlb  [CTLB];
  cta_pkg::cta_tlb_type       dtlbs [DTLB4K];
  cta_pkg::cta_tlb_type       dtlbl [DTLB4M];

  logic                 m_wr;
  logic [1:0]           m_inv;
  logic                 m_il;
  logic                 m_ilc;
  logic [SW-1:0]        m_ils;
  logic [WW-1:0]        m_ilw;
  logic [2:0]           t_wr;
  logic [5:0]           t_ent;
  cta_pkg::cta_tlb_type t_new;

  function automatic logic is_valid(input logic c,
                                    input logic [cta_pkg::STAT_W-1:0] s);
    logic [1:0] v;
    v = s[cta_pkg::VAL_LSB +: 2];
    is_valid = c ? (v != cta_pkg::VAL_INV) : v[0];
  endfunction

  // Hit lookup by address; returns hit flag and way.
  function automatic logic [WW:0] find(input logic c, input logic [31:0] a);
    logic [cta_pkg::STAT_W-1:0] s;
    find = '0;
    for (int w = 0; w < WAYS; w++) begin
      s = cstat[c][a[cta_pkg::LINE_LSB +: SW]][w];
      if (is_valid(c, s) && s[cta_pkg::TAG_LSB +: cta_pkg::TAG_W] ==
          a[cta_pkg::ATAG_LSB +: cta_pkg::TAG_W]) begin
        find = {1'b1, WW'(w)};
      end
    end
  endfunction

  function automatic logic [LW-1:0] line_of(input logic [SW-1:0] s,
                                            input logic [WW-1:0] w);
    line_of = '0;
    for (int i = 0; i < WORDS; i++) begin
      line_of[i*32 +: 32] = cdata[1][s][w][i];
    end
  endfunction

  // Write-back of a modified data line: address rebuilt from tag and set.
  function automatic logic [31:0] addr_of(input logic [SW-1:0] s,
                                          input logic [WW-1:0] w);
    addr_of = 32'({cstat[1][s][w][cta_pkg::TAG_LSB +: cta_pkg::TAG_W], s,
                   {cta_pkg::LINE_LSB{1'b0}}});
  endfunction

  always_comb begin
    logic [1:0]           cmd;
    logic [WW-1:0]        way;
    logic [SW-1:0]        set;
    logic [BW-1:0]        bsel;
    logic [WW:0]          fd;
    logic [WW:0]          fo;
    logic [SW-1:0]        ss;
    logic [19:0]          lin;
    logic                 hit;
    logic                 big;
    logic [5:0]           ix;
    cta_pkg::cta_tlb_type e;
    n = r;
    m_wr = 1'b0;
    m_inv = 2'b00;
    m_il = 1'b0;
    m_ilc = 1'b0;
    m_ils = '0;
    m_ilw = '0;
    t_wr = 3'b000;
    t_ent = '0;
    t_new = '0;
    cmd = msr_wdata[cta_pkg::CMD_LSB +: 2];
    way = msr_wdata[cta_pkg::WAY_LSB +: WW];
    if (WAYS <= 2) begin
      way[1] = 1'b0;
    end
    set = msr_wdata[cta_pkg::SET_LSB +: SW];
    bsel = msr_wdata[cta_pkg::BUF_LSB +: BW];
    fd = find(1'b1, snoop_addr);
    fo = find(1'b0, snoop_addr);
    ss = snoop_addr[cta_pkg::LINE_LSB +: SW];
    lin = msr_wdata[cta_pkg::LIN_LSB +: 20];
    hit = 1'b0;
    big = 1'b0;
    ix = '0;
    e = '0;
    n.fs1 = flush_pin_n;
    n.fs2 = r.fs1;
    n.rvalid = msr_rd;
    n.rdata = '0;
    n.go = 1'b0;
    n.wbreq = 1'b0;
    if (!r.fs2) begin
      n.fpend = 1'b1;
    end
    if (msr_rd) begin
      if (msr_index == cta_pkg::IDX_END) begin
        n.rdata[3:0] = r.tr2;
      end else if (msr_index == cta_pkg::IDX_DATA) begin
        n.rdata = r.tr3;
      end else if (msr_index == cta_pkg::IDX_STAT) begin
        n.rdata = r.tr4;
      end else if (msr_index == cta_pkg::IDX_TLBC) begin
        n.rdata = r.tr6;
      end else if (msr_index == cta_pkg::IDX_TLBD) begin
        n.rdata = r.tr7;
      end
    end
    case (r.st)
      cta_pkg::ST_IDLE: begin
        if (instr_boundary && r.fpend) begin
          n.st = cta_pkg::ST_WALK;
          n.walk = '0;
          n.busy = 1'b1;
          // A pin sample still low here keeps the next flush pending.
          n.fpend = !r.fs2;
        end else if (msr_wr) begin
          if (msr_index == cta_pkg::IDX_END) begin
            n.tr2 = msr_wdata[3:0];
            n.fend[r.bsel] = msr_wdata[3:0];
          end else if (msr_index == cta_pkg::IDX_DATA) begin
            n.tr3 = msr_wdata;
            n.fill[r.bsel] = msr_wdata;
          end else if (msr_index == cta_pkg::IDX_STAT) begin
            n.tr4 = msr_wdata;
          end else if (msr_index == cta_pkg::IDX_CTRL) begin
            n.csel = msr_wdata[cta_pkg::CSEL_BIT];
            n.wb = msr_wdata[cta_pkg::WB_BIT];
            n.way = way;
            n.set = set;
            n.bsel = bsel;
            case (cmd)
              cta_pkg::CMD_WRITE: m_wr = 1'b1;
              cta_pkg::CMD_READ: begin
                n.tr3 = cdata[n.csel][set][way][bsel];
                n.tr2 = n.csel ? 4'h0 : cend[set][way][bsel];
                n.tr4 = 32'(cstat[n.csel][set][way]);
              end
              cta_pkg::CMD_FLUSH: begin
                if (!n.csel) begin
                  m_inv[0] = 1'b1;
                end else if (!n.wb) begin
                  m_inv[1] = 1'b1;
                end else begin
                  m_il = 1'b1;
                  m_ilc = 1'b1;
                  m_ils = set;
                  m_ilw = way;
                  n.wbreq = cstat[1][set][way][cta_pkg::VAL_LSB +: 2] ==
                            cta_pkg::VAL_MOD;
                  n.wbaddr = addr_of(set, way);
                  n.wbline = line_of(set, way);
                end
              end
              default: ;
            endcase
          end else if (msr_index == cta_pkg::IDX_TLBC) begin
            n.tr6 = msr_wdata;
            t_ent = r.tr7[cta_pkg::ENT_LSB +: cta_pkg::ENT_W];
            t_new.tag = lin;
            t_new.pa = r.tr7[cta_pkg::PA_LSB +: 20];
            t_new.attr = r.tr7[cta_pkg::ATTR_LSB +: 2];
            t_new.v = msr_wdata[cta_pkg::V_BIT];
            t_new.u = msr_wdata[cta_pkg::U_BIT];
            if (msr_wdata[cta_pkg::TSEL_BIT]) begin
              t_new.d = msr_wdata[cta_pkg::D_BIT];
              t_new.w = msr_wdata[cta_pkg::W_BIT];
            end
            if (!msr_wdata[cta_pkg::OP_BIT]) begin
              if (!msr_wdata[cta_pkg::TSEL_BIT]) begin
                t_wr[0] = 1'b1;
              end else if (msr_wdata[cta_pkg::PS_BIT]) begin
                t_wr[2] = 1'b1;
              end else begin
                t_wr[1] = 1'b1;
              end
            end else begin
              if (!msr_wdata[cta_pkg::TSEL_BIT]) begin
                for (int i = 0; i < CTLB; i++) begin
                  if (ctlb[i].v && ctlb[i].tag == lin) begin
                    hit = 1'b1;
                    e = ctlb[i];
                    ix = 6'(i);
                  end
                end
                n.tr6[31:cta_pkg::LIN_LSB] = '0;
              end else begin
                for (int i = 0; i < DTLB4K; i++) begin
                  if (dtlbs[i].v && dtlbs[i].tag == lin) begin
                    hit = 1'b1;
                    e = dtlbs[i];
                    ix = 6'(i);
                  end
                end
                for (int i = 0; i < DTLB4M; i++) begin
                  if (dtlbl[i].v && dtlbl[i].tag[19:cta_pkg::PG4M_LSB] ==
                      lin[19:cta_pkg::PG4M_LSB]) begin
                    hit = 1'b1;
                    big = 1'b1;
                    e = dtlbl[i];
                    ix = 6'(i);
                  end
                end
              end
              n.tr7[cta_pkg::HIT_BIT] = hit;
              if (hit) begin
                n.tr7[cta_pkg::PA_LSB +: 20] = e.pa;
                n.tr7[cta_pkg::ENT_LSB +: cta_pkg::ENT_W] = ix;
                n.tr7[cta_pkg::ATTR_LSB +: 2] = e.attr;
              end
              n.tr6[cta_pkg::V_BIT] = e.v;
              n.tr6[cta_pkg::D_BIT] = e.d;
              n.tr6[cta_pkg::U_BIT] = e.u;
              n.tr6[cta_pkg::W_BIT] = e.w;
              n.tr6[cta_pkg::PS_BIT] = big;
            end
          end else if (msr_index == cta_pkg::IDX_TLBD) begin
            n.tr7 = msr_wdata;
          end
        end else if (data_req || code_req) begin
          n.go = 1'b1;
          if (cache_disable_ctrl && data_req && !r.csel && !fd[WW] &&
              fo[WW]) begin
            m_il = 1'b1;
            m_ils = ss;
            m_ilw = fo[WW-1:0];
          end else if (cache_disable_ctrl && code_req && r.csel &&
                       !fo[WW] && fd[WW]) begin
            m_il = 1'b1;
            m_ilc = 1'b1;
            m_ils = ss;
            m_ilw = fd[WW-1:0];
            n.wbreq = cstat[1][ss][fd[WW-1:0]][cta_pkg::VAL_LSB +: 2] ==
                      cta_pkg::VAL_MOD;
            n.wbaddr = addr_of(ss, fd[WW-1:0]);
            n.wbline = line_of(ss, fd[WW-1:0]);
          end
        end
      end
      cta_pkg::ST_WALK: begin
        n.walk = r.walk + 1'b1;
        n.wbreq = cstat[1][r.walk[WW +: SW]][r.walk[WW-1:0]]
                  [cta_pkg::VAL_LSB +: 2] == cta_pkg::VAL_MOD;
        n.wbaddr = addr_of(r.walk[WW +: SW], r.walk[WW-1:0]);
        n.wbline = line_of(r.walk[WW +: SW], r.walk[WW-1:0]);
        if (r.walk == (SW+WW)'(SETS*WAYS-1)) begin
          m_inv = 2'b11;
          n.st = cta_pkg::ST_IDLE;
          n.busy = 1'b0;
        end
      end
      default: n.st = cta_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '0;
      // The synchroniser rests at the idle pin level: no false flush.
      r.fs1 <= 1'b1;
      r.fs2 <= 1'b1;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < SETS; s++) begin
        for (int w = 0; w < WAYS; w++) begin
          if (rst || m_inv[c]) begin
            cstat[c][s][w][cta_pkg::VAL_LSB +: 2] <= cta_pkg::VAL_INV;
          end
        end
      end
    end
    if (m_il) begin
      cstat[m_ilc][m_ils][m_ilw][cta_pkg::VAL_LSB +: 2] <= cta_pkg::VAL_INV;
    end
    if (m_wr) begin
      cstat[n.csel][n.set][n.way] <= r.tr4[cta_pkg::STAT_W-1:0];
      for (int i = 0; i < WORDS; i++) begin
        cdata[n.csel][n.set][n.way][i] <= r.fill[i];
        cend[n.set][n.way][i] <= r.fend[i];
      end
    end
    for (int i = 0; i < CTLB; i++) begin
      if (rst) ctlb[i].v <= 1'b0;
    end
    for (int i = 0; i < DTLB4K; i++) begin
      if (rst) dtlbs[i].v <= 1'b0;
    end
    for (int i = 0; i < DTLB4M; i++) begin
      if (rst) dtlbl[i].v <= 1'b0;
    end
    if (t_wr[0]) ctlb[t_ent[$clog2(CTLB)-1:0]] <= t_new;
    if (t_wr[1]) dtlbs[t_ent[$clog2(DTLB4K)-1:0]] <= t_new;
    if (t_wr[2]) dtlbl[t_ent[$clog2(DTLB4M)-1:0]] <= t_new;
  end

  assign msr_rdata = r.rdata;
  assign msr_rvalid = r.rvalid;
  assign ext_cycle_go = r.go;
  assign flush_busy = r.busy;
  assign wb_req = r.wbreq;
  assign wb_addr = r.wbaddr;
  assign wb_line = r.wbline;

  ctrl_wo_a: assert property (@(posedge ref_clk) disable iff (rst)
    msr_rd && msr_index == cta_pkg::IDX_CTRL |=> msr_rdata == 32'h0000_0000)
    else $error("control register did not read as zero");
  stat_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    msr_wr && msr_index == cta_pkg::IDX_CTRL && r.st == cta_pkg::ST_IDLE &&
    !(instr_boundary && r.fpend) && msr_wdata[1:0] == cta_pkg::CMD_READ
    |=> r.tr4[31:cta_pkg::STAT_W] == '0 &&
        r.tr4[cta_pkg::STAT_W-1:0] == cstat[r.csel][r.set][r.way])
    else $error("test read status mismatch");
  code_flush_a: assert property (@(posedge ref_clk) disable iff (rst)
    m_inv[0] |=> !cstat[0][r.set][r.way][cta_pkg::VAL_LSB])
    else $error("code cache entry still valid after flush");
  line_wb_a: assert property (@(posedge ref_clk) disable iff (rst)
    m_il && m_ilc && r.st == cta_pkg::ST_IDLE &&
    cstat[1][m_ils][m_ilw][1:0] == cta_pkg::VAL_MOD
    |=> wb_req && cstat[1][$past(m_ils)][$past(m_ilw)][1:0] ==
        cta_pkg::VAL_INV)
    else $error("modified line not written back and invalidated");
  ext_go_a: assert property (@(posedge ref_clk) disable iff (rst)
    (data_req || code_req) && !msr_wr && r.st == cta_pkg::ST_IDLE &&
    !(instr_boundary && r.fpend) |=> ext_cycle_go)
    else $error("external cycle not released after lookup");
  flush_start_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(flush_busy) |-> $past(instr_boundary) && !wb_req)
    else $error("flush started off an instruction boundary");
  tlb_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    msr_wr && msr_index == cta_pkg::IDX_TLBC && !msr_wdata[0] &&
    r.st == cta_pkg::ST_IDLE |=> $stable(r.tr7))
    else $error("TLB write altered the data register");
  code_tlb_a: assert property (@(posedge ref_clk) disable iff (rst)
    t_wr[0] |=> !ctlb[$past(t_ent[4:0])].d && !ctlb[$past(t_ent[4:0])].w)
    else $error("code TLB stored data-only bits");
endmodule // cta_test_access

// ---- sim/tb.sv ----
// Self-checking bench for the cache and TLB test access block.
`timescale 1ns/1ps
module tb;
  logic         ref_clk = 0;
  logic         rst = 1;
  logic         msr_wr = 0;
  logic         msr_rd = 0;
  logic [7:0]   msr_index = 0;
  logic [31:0]  msr_wdata = 0;
  logic [31:0]  msr_rdata;
  logic         msr_rvalid;
  logic         code_req = 0;
  logic         data_req = 0;
  logic [31:0]  snoop_addr = 0;
  logic         ext_cycle_go;
  logic         wb_req;
  logic [31:0]  wb_addr;
  logic [255:0] wb_line;
  logic         cache_disable_ctrl = 1;
  logic         flush_pin_n = 1;
  logic         instr_boundary = 0;
  logic         flush_busy;
  logic [31:0]  last_wb;
  logic [31:0]  got;
  int           wb_count = 0;
  int           n;
  int           failures = 0;
  int           compares = 0;
  int           cycles = 0;

  always #12.5 ref_clk = ~ref_clk;

  cta_test_access cta_test_access_inst (
    .ref_clk(ref_clk), .rst(rst), .msr_wr(msr_wr), .msr_rd(msr_rd),
    .msr_index(msr_index), .msr_wdata(msr_wdata), .msr_rdata(msr_rdata),
    .msr_rvalid(msr_rvalid), .cache_disable_ctrl(cache_disable_ctrl),
    .data_req(data_req), .code_req(code_req), .snoop_addr(snoop_addr),
    .ext_cycle_go(ext_cycle_go), .flush_pin_n(flush_pin_n),
    .instr_boundary(instr_boundary), .flush_busy(flush_busy),
    .wb_req(wb_req), .wb_addr(wb_addr), .wb_line(wb_line));

  task automatic print_verdict();
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Counts write-back pulses mid-cycle, where they are settled.
  always @(negedge ref_clk) begin
    cycles++;
    if (wb_req === 1'b1) begin
      wb_count++;
      last_wb = wb_addr;
    end
    if (cycles > 20000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    msr_wr = 1;
    msr_index = idx;
    msr_wdata = d;
    @(posedge ref_clk);
    #1 msr_wr = 0;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] idx);
    msr_rd = 1;
    msr_index = idx;
    @(posedge ref_clk);
    #1 msr_rd = 0;
    chk("rvalid", {31'h0, msr_rvalid}, 32'h1);
    got = msr_rdata;
    @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [31:0] ctl(input logic wb, cs,
      input logic [1:0] way, input logic [6:0] set, input logic [2:0] bf,
      input logic [1:0] cmd);
    return {16'h0, wb, cs, way, set, bf, cmd};
  endfunction

  function automatic logic [31:0] word(input logic [1:0] way,
      input logic [6:0] set, input logic [2:0] k);
    return {8'hA5, 1'b0, set, 2'h0, way, 9'h0, k};
  endfunction

  task automatic wline(input logic cs, input logic [1:0] way,
      input logic [6:0] set, input logic [19:0] tag, input logic [1:0] v);
    for (int k = 0; k < 8; k++) begin
      wr(cta_pkg::IDX_CTRL, ctl(1'b0, cs, way, set, 3'(k), 2'h0));
      wr(cta_pkg::IDX_DATA, word(way, set, 3'(k)));
    end
    wr(cta_pkg::IDX_STAT, {4'hF, tag, 6'h2A, v});
    wr(cta_pkg::IDX_CTRL, ctl(1'b0, cs, way, set, 3'h0, 2'h1));
  endtask

  // Reads the words when asked, then leaves the status word in got.
  task automatic rline(input logic cs, input logic [1:0] way,
      input logic [6:0] set, input logic words);
    for (int k = 0; k < 8; k++) begin
      wr(cta_pkg::IDX_CTRL, ctl(1'b0, cs, way, set, 3'(k), 2'h2));
      if (words) begin
        rd(cta_pkg::IDX_DATA);
        chk("line word", got, word(way, set, 3'(k)));
      end
    end
    rd(cta_pkg::IDX_STAT);
  endtask

  task automatic snoop(input logic code, input logic [31:0] a);
    code_req = code;
    data_req = !code;
    snoop_addr = a;
    @(posedge ref_clk);
    #1 code_req = 0;
    data_req = 0;
    chk("ext go", {31'h0, ext_cycle_go}, 32'h1);
  endtask

  task automatic tlbrd(input logic [19:0] lin, input logic tsel);
    wr(cta_pkg::IDX_TLBC, {lin, 10'h0, tsel, 1'b1});
    rd(cta_pkg::IDX_TLBD);
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    #1 rst = 0;
    wline(1'b1, 2'h0, 7'h7F, 20'h1_1111, 2'h1);
    wline(1'b1, 2'h3, 7'h7F, 20'h2_2222, 2'h3);
    rline(1'b1, 2'h0, 7'h7F, 1'b1);
    chk("status", got, {4'h0, 20'h1_1111, 6'h2A, 2'h1});
    rline(1'b1, 2'h3, 7'h7F, 1'b1);
    chk("status", got, {4'h0, 20'h2_2222, 6'h2A, 2'h3});
    rd(cta_pkg::IDX_CTRL);
    chk("control read", got, 32'h0);
    n = wb_count;
    wr(cta_pkg::IDX_CTRL, ctl(1'b1, 1'b1, 2'h3, 7'h7F, 3'h0, 2'h3));
    repeat (3) @(posedge ref_clk);
    chk("wb count", 32'(wb_count - n), 32'h1);
    chk("wb addr", last_wb, {20'h2_2222, 7'h7F, 5'h0});
    rline(1'b1, 2'h3, 7'h7F, 1'b0);
    chk("line valid", {30'h0, got[1:0]}, 32'h0);
    rline(1'b1, 2'h0, 7'h7F, 1'b0);
    chk("other way", {30'h0, got[1:0]}, 32'h1);
    wr(cta_pkg::IDX_CTRL, ctl(1'b0, 1'b1, 2'h0, 7'h00, 3'h0, 2'h3));
    rline(1'b1, 2'h0, 7'h7F, 1'b0);
    chk("data flush", {30'h0, got[1:0]}, 32'h0);
    wline(1'b1, 2'h1, 7'h05, 20'h1_2345, 2'h3);
    snoop(1'b1, {20'h1_2345, 7'h05, 5'h0});
    chk("snoop wb", {31'h0, wb_req}, 32'h1);
    chk("snoop addr", wb_addr, {20'h1_2345, 7'h05, 5'h0});
    chk("snoop line", wb_line[31:0], word(2'h1, 7'h05, 3'h0));
    rline(1'b1, 2'h1, 7'h05, 1'b0);
    chk("snoop inv", {30'h0, got[1:0]}, 32'h0);
    wline(1'b0, 2'h2, 7'h09, 20'h0_ABCD, 2'h1);
    snoop(1'b0, {20'h0_ABCD, 7'h09, 5'h0});
    rline(1'b0, 2'h2, 7'h09, 1'b0);
    chk("code inv", {31'h0, got[0]}, 32'h0);
    wline(1'b0, 2'h2, 7'h09, 20'h0_ABCD, 2'h1);
    cache_disable_ctrl = 0;
    snoop(1'b0, {20'h0_ABCD, 7'h09, 5'h0});
    rline(1'b0, 2'h2, 7'h09, 1'b0);
    chk("no test op", {31'h0, got[0]}, 32'h1);
    cache_disable_ctrl = 1;
    wr(cta_pkg::IDX_CTRL, ctl(1'b1, 1'b0, 2'h0, 7'h00, 3'h0, 2'h3));
    rline(1'b0, 2'h2, 7'h09, 1'b0);
    chk("code flush", {31'h0, got[0]}, 32'h0);
    wr(cta_pkg::IDX_TLBD, {20'hA_BCDE, 1'b0, 6'h03, 1'b1, 2'h2, 2'h0});
    wr(cta_pkg::IDX_TLBC, {20'h5_5555, 4'hD, 1'b0, 5'h0, 2'h2});
    tlbrd(20'h5_5555, 1'b1);
    chk("tlb hit", {31'h0, got[4]}, 32'h1);
    chk("tlb pa", {12'h0, got[31:12]}, 32'h000A_BCDE);
    rd(cta_pkg::IDX_TLBC);
    chk("tlb bits", {27'h0, got[11:7]}, 32'h0000_001A);
    tlbrd(20'h5_5556, 1'b1);
    chk("tlb miss", {31'h0, got[4]}, 32'h0);
    wr(cta_pkg::IDX_TLBD, {20'h0_1234, 1'b0, 6'h01, 1'b1, 4'h0});
    wr(cta_pkg::IDX_TLBC, {20'h5_5555, 4'h8, 1'b1, 5'h0, 2'h2});
    tlbrd(20'h5_5555, 1'b1);
    rd(cta_pkg::IDX_TLBC);
    chk("both hit ps", {31'h0, got[7]}, 32'h1);
    wr(cta_pkg::IDX_TLBD, {20'h0_0777, 1'b0, 6'h05, 1'b1, 4'h0});
    wr(cta_pkg::IDX_TLBC, {20'h0_F0F0, 4'hD, 1'b1, 5'h0, 2'h0});
    tlbrd(20'h0_F0F0, 1'b0);
    chk("code tlb", {11'h0, got[31:12], got[4]}, 32'h0000_0EEF);
    rd(cta_pkg::IDX_TLBC);
    chk("code bits", {got[31:12], 7'h0, got[11:7]}, 32'h0000_0010);
    tlbrd(20'h0_F0F3, 1'b0);
    chk("code 4k", {31'h0, got[4]}, 32'h0);
    wline(1'b1, 2'h2, 7'h10, 20'h3_3333, 2'h3);
    wline(1'b0, 2'h0, 7'h11, 20'h4_4444, 2'h1);
    n = wb_count;
    flush_pin_n = 0;
    repeat (2) @(posedge ref_clk);
    #1 flush_pin_n = 1;
    repeat (2) @(posedge ref_clk);
    #1 instr_boundary = 1;
    @(posedge ref_clk);
    #1 instr_boundary = 0;
    chk("flush busy", {31'h0, flush_busy}, 32'h1);
    repeat (520) @(posedge ref_clk);
    #1;
    chk("flush done", {31'h0, flush_busy}, 32'h0);
    chk("flush wb", 32'(wb_count - n), 32'h1);
    chk("flush addr", last_wb, {20'h3_3333, 7'h10, 5'h0});
    rline(1'b1, 2'h2, 7'h10, 1'b0);
    chk("flush data", {30'h0, got[1:0]}, 32'h0);
    rline(1'b0, 2'h0, 7'h11, 1'b0);
    chk("flush code", {31'h0, got[0]}, 32'h0);
    print_verdict();
  end
endmodule // tb
